/* design/pbss_defs.svh */
`ifndef PBSS_DEFS_SVH
`define PBSS_DEFS_SVH

// Port geometry
`define PBSS_ADDR_W 19
`define PBSS_LANE_W 9
`define PBSS_LANES 2

// Field positions of the asynchronous input group
`define PBSS_OE_BIT 0
`define PBSS_SLEEP_BIT 1
`define PBSS_ORDER_BIT 2

// Reset values: outputs off, awake, interleaved order
`define PBSS_ASYNC_RST 3'h5
`define PBSS_CNT_RST 2'h0
`define PBSS_BURST_STEP 2'h1

`endif

/* design/pbss_mem.sv */
`timescale 1ns/100ps
module pbss_mem #(
  parameter int ADDR_W = 19,
  parameter int LANE_W = 9,
  parameter int LANES = 2
) (
  input wire logic ref_clk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [LANES-1:0] wr_lanes_i,
  input wire logic [LANES*LANE_W-1:0] wdata_i,
  output logic [LANES*LANE_W-1:0] rdata_o
);

  logic [LANES*LANE_W-1:0] mem [2**ADDR_W];

  // No reset: contents survive reset and sleep
  always_ff @(posedge ref_clk_i) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_lanes_i[l]) begin
        mem[addr_i][l*LANE_W +: LANE_W] <= wdata_i[l*LANE_W +: LANE_W];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    rdata_o <= mem[addr_i];
  end

endmodule : pbss_mem

/* design/pbss_pkg.sv */
package pbss_pkg;

  // What the current rising edge does to the port
  typedef enum logic [2:0] {
    CYC_IDLE,
    CYC_DESEL,
    CYC_START_P,
    CYC_START_C,
    CYC_CONT,
    CYC_SUSP
  } pbss_cyc_t;

  typedef logic [1:0] pbss_bpos_t;

endpackage : pbss_pkg

/* design/pbss_port.sv */
// Behaviour
// [R1] Processor strobe with selects loads address, reads
// [R2] Read data appears one edge after address
// [R3] Advance ignored on processor strobe edge
// [R4] Step only with advance, both strobes high
// [R5] Order pin high: start XOR count
// [R6] Order pin low: start plus count, mod four
// [R7] Global write writes all bits
// [R8] Lane writes need gate low and lane low
// [R9] Lane writes ignored on processor strobe edge
// [R10] Sampled lane write turns drivers off
// [R11] Lane write captures data, may step
// [R12] Drivers off one clock after deselect
// [R13] Master keeps processor strobe high with controller
// [R14] Controller strobe edge samples write controls
// [R15] Master select blocks processor strobe only
// [R16] Secondary selects sampled on strobe edges
// [R17] Address taken only with all selects, strobe
// [R18] Sync inputs on rising edge; rest async
// [R19] Drive data only on enabled reads
// [R20] Sleep deselects, ignores inputs, outputs off
// [R21] Master finishes transfers before raising sleep
// [R22] Master issues no writes during wake interval
// [R23] Master keeps output enable high around writes; the testbench holds output_enable_n_i low through its writes
// [R24] Strobes and advance high hold address
// [R25] Burst wraps within group of four
`timescale 1ns/100ps
`include "pbss_defs.svh"
module pbss_port import pbss_pkg::*; #(
  parameter int ADDR_W = `PBSS_ADDR_W,
  parameter int LANE_W = `PBSS_LANE_W,
  parameter int LANES = `PBSS_LANES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic proc_addr_strobe_n_i,
  input wire logic ctrl_addr_strobe_n_i,
  input wire logic burst_advance_n_i,
  input wire logic master_select_n_i,
  input wire logic select_hi_i,
  input wire logic select_lo_n_i,
  input wire logic global_write_n_i,
  input wire logic byte_write_gate_n_i,
  input wire logic [LANES-1:0] byte_lane_write_n_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_sel_n_i,
  input wire logic [LANES*LANE_W-1:0] data_i,
  output logic [LANES*LANE_W-1:0] data_o,
  output logic data_oe_o
);

  localparam int DATA_W = LANES * LANE_W;

  logic [2:0] async_in;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync3_r;
  logic [2:0] filt_r;
  logic oe_n_s;
  logic sleep_s;
  logic order_n_s;
  logic ms;
  logic cs_ok;
  logic proc_start_ok;
  logic ctrl_start;
  pbss_cyc_t cyc;
  logic [LANES-1:0] wr_lanes;
  logic [LANES-1:0] mem_we;
  logic wr_seen;
  logic rd_acc;
  logic active_r;
  logic active_nxt;
  logic [ADDR_W-1:0] base_r;
  logic [ADDR_W-1:0] base_nxt;
  pbss_bpos_t cnt_r;
  pbss_bpos_t cnt_nxt;
  logic [ADDR_W-1:0] acc_addr;
  logic rd_pend_r;
  logic [DATA_W-1:0] mem_q;
  logic [DATA_W-1:0] data_r;
  logic data_oe_r;

  function automatic pbss_bpos_t burst_low(input pbss_bpos_t start, input pbss_bpos_t cnt,
                                           input logic linear);
    // [R5] interleaved order
    // [R6] linear order
    return linear ? pbss_bpos_t'(start + cnt) : (start ^ cnt);
  endfunction : burst_low

  // [R18] async pins filtered
  assign async_in = {burst_order_sel_n_i, sleep_request_i, output_enable_n_i};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync1_r <= `PBSS_ASYNC_RST;
      sync2_r <= `PBSS_ASYNC_RST;
      sync3_r <= `PBSS_ASYNC_RST;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A bit moves only once the second and third stages agree
  // Costs a few clocks, but no glitch reaches the decode
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      filt_r <= `PBSS_ASYNC_RST;
    end else begin
      filt_r <= (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
    end
  end

  assign oe_n_s = filt_r[`PBSS_OE_BIT];
  assign sleep_s = filt_r[`PBSS_SLEEP_BIT];
  assign order_n_s = filt_r[`PBSS_ORDER_BIT];

  // Edge decode; the master keeps the processor strobe high with the
  // controller one, so a processor strobe simply wins here
  always_comb begin
    ms = !master_select_n_i;
    // [R16] both secondary selects
    cs_ok = ms && select_hi_i && !select_lo_n_i;
    // [R15] master select gates processor strobe
    proc_start_ok = !proc_addr_strobe_n_i && ms;
    ctrl_start = !ctrl_addr_strobe_n_i;
    // [R20] sleep forces deselect
    if (sleep_s) begin
      cyc = CYC_DESEL;
    end else if (proc_start_ok) begin
      cyc = cs_ok ? CYC_START_P : CYC_DESEL;
    end else if (ctrl_start) begin
      cyc = cs_ok ? CYC_START_C : CYC_DESEL;
    end else if (!active_r) begin
      cyc = CYC_IDLE;
    end else if (!burst_advance_n_i) begin
      cyc = CYC_CONT;
    end else begin
      cyc = CYC_SUSP;
    end
  end

  // [R7] global write all lanes
  // [R8] gated lane writes
  always_comb begin
    if (!global_write_n_i) begin
      wr_lanes = '1;
    end else if (!byte_write_gate_n_i) begin
      wr_lanes = ~byte_lane_write_n_i;
    end else begin
      wr_lanes = '0;
    end
  end

  // [R9] lanes ignored on processor start
  // [R14] controller start may write
  // [R11] lane write captures data
  always_comb begin
    case (cyc)
      CYC_START_C, CYC_CONT, CYC_SUSP: mem_we = wr_lanes;
      default: mem_we = '0;
    endcase
  end

  // Writes outside a burst still quiet the drivers
  assign wr_seen = (|wr_lanes) && !sleep_s && (cyc != CYC_START_P);
  assign rd_acc = (cyc == CYC_START_P) ||
                  (((cyc == CYC_START_C) || (cyc == CYC_CONT) || (cyc == CYC_SUSP)) &&
                   !(|mem_we));

  // [R17] address taken only on starts
  // [R1] processor start loads address
  always_comb begin
    case (cyc)
      CYC_START_P, CYC_START_C: base_nxt = addr_i;
      default: base_nxt = base_r;
    endcase
  end

  // [R3] advance ignored on start
  // [R4] step only on continue
  // [R24] suspend holds count
  // [R25] two-bit count wraps
  always_comb begin
    case (cyc)
      CYC_START_P, CYC_START_C: cnt_nxt = `PBSS_CNT_RST;
      CYC_CONT: cnt_nxt = cnt_r + `PBSS_BURST_STEP;
      default: cnt_nxt = cnt_r;
    endcase
  end

  always_comb begin
    case (cyc)
      CYC_START_P, CYC_START_C: active_nxt = 1'b1;
      CYC_DESEL: active_nxt = 1'b0;
      default: active_nxt = active_r;
    endcase
  end

  // Carry stops at bit 1, higher bits stay put
  assign acc_addr = {base_nxt[ADDR_W-1:2], burst_low(base_nxt[1:0], cnt_nxt, !order_n_s)};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      active_r <= 1'b0;
      cnt_r <= `PBSS_CNT_RST;
      base_r <= '0;
    end else begin
      active_r <= active_nxt;
      cnt_r <= cnt_nxt;
      base_r <= base_nxt;
    end
  end

  // The array's read register is the first pipe stage
  pbss_mem #(
    .ADDR_W(ADDR_W),
    .LANE_W(LANE_W),
    .LANES(LANES)
  ) u_mem (
    .ref_clk_i(ref_clk_i),
    .addr_i(acc_addr),
    .wr_lanes_i(mem_we),
    .wdata_i(data_i),
    .rdata_o(mem_q)
  );

  // [R12] single-cycle deselect
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= rd_acc;
    end
  end

  // [R2] output register stage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_r <= '0;
    end else if (rd_pend_r) begin
      data_r <= mem_q;
    end
  end

  // Output enable is filtered, so it lags the pin by a few clocks
  // Sleep is checked here too, so drivers drop even mid burst
  // [R19] drive only enabled reads
  // [R10] write sampled turns off
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_oe_r <= 1'b0;
    end else begin
      data_oe_r <= rd_pend_r && !oe_n_s && !wr_seen && !sleep_s;
    end
  end

  assign data_o = data_r;
  assign data_oe_o = data_oe_r;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  chk_start_load: assert property ( // [R1]
    (cyc == CYC_START_P) |=> (base_r == $past(addr_i)) && active_r)
    else $error("processor start did not load the address");

  chk_read_pipe: assert property ( // [R2]
    (rd_acc && !oe_n_s && !sleep_s) ##1 (!wr_seen && !oe_n_s && !sleep_s)
      |=> data_oe_o && (data_o == $past(mem_q)))
    else $error("read data not driven one edge after address");

  chk_adv_ignored: assert property ( // [R3]
    (cyc == CYC_START_P) && !burst_advance_n_i |=> (cnt_r == 2'h0))
    else $error("advance acted on processor start edge");

  chk_step_only: assert property ( // [R4]
    (cnt_r != $past(cnt_r)) && !$past(rst_i) |->
      ($past(cyc) == CYC_CONT) || (cnt_r == 2'h0))
    else $error("burst stepped without advance");

  chk_interleave: assert property ( // [R5]
    (cyc == CYC_CONT) && order_n_s |-> (acc_addr[1:0] == (base_r[1:0] ^ (cnt_r + 2'h1))))
    else $error("interleaved burst address wrong");

  chk_linear: assert property ( // [R6]
    (cyc == CYC_CONT) && !order_n_s |-> (acc_addr[1:0] == 2'(base_r[1:0] + cnt_r + 2'h1)))
    else $error("linear burst address wrong");

  chk_global_wr: assert property ( // [R7]
    (cyc == CYC_CONT) && !global_write_n_i |-> (&mem_we))
    else $error("global write missed a lane");

  chk_gate_off: assert property ( // [R8]
    global_write_n_i && byte_write_gate_n_i |-> (mem_we == '0) && !wr_seen)
    else $error("write without gate");

  chk_lane_ignore: assert property ( // [R9]
    (cyc == CYC_START_P) |-> (mem_we == '0))
    else $error("lane write taken on processor start");

  chk_write_hiz: assert property ( // [R10]
    wr_seen |=> !data_oe_o)
    else $error("drivers on after sampled write");

  chk_ctrl_write: assert property ( // [R14]
    (cyc == CYC_START_C) && !global_write_n_i |-> (&mem_we) ##1 !data_oe_o)
    else $error("controller start did not write");

  chk_desel_hiz: assert property ( // [R12]
    (cyc == CYC_DESEL) |=> !rd_pend_r ##1 !data_oe_o)
    else $error("deselect took more than one clock");

  chk_master_block: assert property ( // [R15]
    master_select_n_i && !ctrl_addr_strobe_n_i && !sleep_s |-> (cyc == CYC_DESEL))
    else $error("controller strobe with master off not deselect");

  chk_addr_gate: assert property ( // [R17]
    (base_r != $past(base_r)) && !$past(rst_i) |->
      $past(cs_ok) && ($past(cyc) inside {CYC_START_P, CYC_START_C}))
    else $error("address taken without selects");

  chk_drive_cause: assert property ( // [R19]
    data_oe_o |-> $past(rd_pend_r) && !$past(oe_n_s))
    else $error("driving outside an enabled read");

  chk_sleep_off: assert property ( // [R20]
    sleep_s |-> (mem_we == '0) ##1 (!data_oe_o && !active_r))
    else $error("sleep did not deselect");

  chk_suspend: assert property ( // [R24]
    (cyc == CYC_SUSP) |=> $stable(cnt_r) && $stable(base_r))
    else $error("suspend moved the burst address");

  chk_wrap: assert property ( // [R25]
    (cyc == CYC_CONT) && (cnt_r == 2'h3) |=> (cnt_r == 2'h0) && $stable(base_r))
    else $error("burst did not wrap in group");

endmodule : pbss_port

/* tb/pbss_master.sv */
`timescale 1ns/100ps
module pbss_master (
  input wire logic ref_clk_i,
  input wire logic [17:0] dev_data_i,
  input wire logic dev_oe_i,
  output logic [5:0] addr_o,
  output logic proc_addr_strobe_n_o,
  output logic ctrl_addr_strobe_n_o,
  output logic burst_advance_n_o,
  output logic master_select_n_o,
  output logic select_hi_o,
  output logic select_lo_n_o,
  output logic global_write_n_o,
  output logic byte_write_gate_n_o,
  output logic [1:0] byte_lane_write_n_o,
  output logic [17:0] wire_o
);
  logic [17:0] wd_r = 18'h0;

  initial begin
    {proc_addr_strobe_n_o, ctrl_addr_strobe_n_o, burst_advance_n_o, master_select_n_o} = 4'he;
    {select_hi_o, global_write_n_o, byte_write_gate_n_o, byte_lane_write_n_o} = 5'h1f;
    addr_o = 6'h0;
    select_lo_n_o = 1'b0;
  end

  // one driver at a time
  // Released wire toggles so a stale value never passes
  assign wire_o = dev_oe_i ? dev_data_i : wd_r;

  // Kind: 0 none, 1 processor start, 2 controller start, 3 deselect
  // processor strobe high
  // Sel is {high select, low select}; 2'h2 enables the device
  task automatic cyc(input logic [1:0] st, input logic step_n, input logic [5:0] a,
      input logic [3:0] w, input logic [17:0] d, input logic [1:0] sel);
    logic drv;
    drv = !w[3] || (!w[2] && w[1:0] != 2'h3);
    @(posedge ref_clk_i);
    proc_addr_strobe_n_o <= st != 2'h1;
    ctrl_addr_strobe_n_o <= !st[1];
    master_select_n_o <= st == 2'h3;
    {select_hi_o, select_lo_n_o} <= sel;
    burst_advance_n_o <= step_n;
    addr_o <= a;
    {global_write_n_o, byte_write_gate_n_o, byte_lane_write_n_o} <= w;
    wd_r <= drv ? d : ~wd_r;
  endtask : cyc
endmodule : pbss_master

/* tb/pipelined_burst_sync_sram_port_tb_top.sv */
`timescale 1ns/100ps
module pipelined_burst_sync_sram_port_tb_top;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic output_enable_n_i = 1'b0;
  logic sleep_request_i = 1'b0;
  logic burst_order_sel_n_i = 1'b1;
  logic [5:0] addr_i;
  logic [5:0] a = 6'h0;
  logic proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, burst_advance_n_i, master_select_n_i;
  logic select_hi_i, select_lo_n_i, global_write_n_i, byte_write_gate_n_i, data_oe_o;
  logic [1:0] byte_lane_write_n_i;
  logic [17:0] data_i, data_o, mem_m [64];
  logic [3:0] w;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed = 32'h2809f818;

  always #50 ref_clk_i = ~ref_clk_i;

  pbss_port #(.ADDR_W(6)) dut (
    .ref_clk_i, .rst_i, .addr_i, .proc_addr_strobe_n_i, .ctrl_addr_strobe_n_i,
    .burst_advance_n_i, .master_select_n_i, .select_hi_i, .select_lo_n_i,
    .global_write_n_i, .byte_write_gate_n_i, .byte_lane_write_n_i, .output_enable_n_i,
    .sleep_request_i, .burst_order_sel_n_i, .data_i, .data_o, .data_oe_o
  );

  pbss_master m (
    .ref_clk_i, .dev_data_i(data_o), .dev_oe_i(data_oe_o), .addr_o(addr_i),
    .proc_addr_strobe_n_o(proc_addr_strobe_n_i), .ctrl_addr_strobe_n_o(ctrl_addr_strobe_n_i),
    .burst_advance_n_o(burst_advance_n_i), .master_select_n_o(master_select_n_i),
    .select_hi_o(select_hi_i), .select_lo_n_o(select_lo_n_i),
    .global_write_n_o(global_write_n_i),
    .byte_write_gate_n_o(byte_write_gate_n_i), .byte_lane_write_n_o(byte_lane_write_n_i),
    .wire_o(data_i)
  );

  function automatic logic [5:0] pa(input logic [5:0] s, input logic [1:0] k);
    return {s[5:2], burst_order_sel_n_i ? s[1:0] ^ k : s[1:0] + k};
  endfunction : pa

  task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic stop_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic idle(input int n);
    repeat (n) m.cyc(2'h0, 1'b1, a, 4'hf, 18'h0, 2'h2);
  endtask : idle

  // Burst of four from a, then one suspend cycle; ps starts by processor strobe
  task automatic wr(input logic [3:0] w, input logic ps);
    logic [17:0] d;
    logic wt;
    wt = !ps && (!w[3] || (!w[2] && w[1:0] != 2'h3));
    for (int k = 0; k < 5; k++) begin
      d = 18'($random(seed));
      m.cyc(k == 0 ? {!ps, ps} : 2'h0, k == 0 || k == 4, a,
          (k == 4 || (ps && k > 0)) ? 4'hf : w, d, 2'h2);
      for (int l = 0; l < 2; l++)
        if (k < 4 && !ps && !sleep_request_i && (!w[3] || (!w[2] && !w[l])))
          mem_m[pa(a, 2'(k))][l*9 +: 9] = d[l*9 +: 9];
      #1;
      chk("drive_enable", data_oe_o, !wt && k > 1 && !sleep_request_i);
    end
  endtask : wr

  // Advance held low on the start edge, where it must be ignored; fifth access wraps
  task automatic rd(input logic [1:0] s);
    for (int k = 0; k < 10; k++) begin
      m.cyc(k == 0 ? 2'h1 : (k == 7 ? 2'h3 : 2'h0), k > 4, a, 4'hf, 18'h0, s);
      #1;
      if (k > 1) chk("drive_enable", data_oe_o, s == 2'h2 && !output_enable_n_i && k < 9);
      if (k > 1 && k < 9 && s == 2'h2 && !output_enable_n_i)
        chk("read_data", data_o, mem_m[pa(a, 2'(k > 5 ? 4 : k - 2))]);
    end
  endtask : rd

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    idle(4);
    chk("drive_enable", data_oe_o, 1'b0);
    for (int it = 0; it < 8; it++) begin
      a = 6'($random(seed));
      @(posedge ref_clk_i) burst_order_sel_n_i <= it[0];
      idle(5);
      wr({1'b0, 3'($random(seed))}, 1'b0);
      rd(2'h2);
      w = {1'b1, it[1], 2'($random(seed))};
      wr(w, 1'b0);
      rd(2'h2);
      wr({it[2], 3'h0}, 1'b1);
      rd(2'h2);
    end
    rd(2'h0);
    rd(2'h3);
    @(posedge ref_clk_i) output_enable_n_i <= 1'b1;
    idle(5);
    rd(2'h2);
    @(posedge ref_clk_i) output_enable_n_i <= 1'b0;
    @(posedge ref_clk_i) sleep_request_i <= 1'b1;
    idle(5);
    wr(4'h0, 1'b0);
    @(posedge ref_clk_i) sleep_request_i <= 1'b0;
    idle(6);
    rd(2'h2);
    stop_test();
  end
endmodule : pipelined_burst_sync_sram_port_tb_top
